// ==== common/dei_pkg.sv ====
// dei_pkg: constants and carriers for the drive enable / fault interlock.
// assumes one 250 MHz system clock and a plain word-wide register port.
package dei_pkg;

	// clock and timing
	localparam int CLK_MHZ        = 250;
	localparam int DEBOUNCE_US    = 5000;
	localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
	localparam int SHORT_PRESS_US = 1000000;
	localparam int SHORT_CYC      = SHORT_PRESS_US * CLK_MHZ;
	localparam int DOUT_REFR_NS   = 250000;
	localparam int DOUT_REFR_CYC  = DOUT_REFR_NS * CLK_MHZ / 1000;
	localparam int CNT_W          = 28;

	// register map, byte addresses
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_STATE = 8'h04;
	localparam logic [7:0] ADDR_ISTAT = 8'h08;
	localparam logic [7:0] ADDR_IMASK = 8'h0c;

	// control fields
	localparam int CTRL_SW_EN   = 0;
	localparam int CTRL_MODE    = 1;
	localparam int CTRL_SEL_LO  = 2;
	localparam int SEL_W        = 3;
	localparam logic [4:0] CTRL_RST = 5'h00;

	// interrupt event bits
	localparam int EV_W          = 4;
	localparam int EV_FAULT      = 0;
	localparam int EV_PERM_ONE   = 1;
	localparam int EV_PERM_TWO   = 2;
	localparam int EV_SHORT_PUSH = 3;
	localparam logic [EV_W-1:0] EV_RST = 4'h0;

	// synchronised pin inputs
	typedef struct packed {
		logic front_pushbutton;
		logic string_two_torque_permit;
		logic string_one_torque_permit;
		logic hw_enable;
	} dei_pins_s;

	// software control register
	typedef struct packed {
		logic [SEL_W-1:0] dout_sel;
		logic             relay_mode;
		logic             sw_enable;
	} dei_ctrl_s;

	// digital output sources
	typedef enum logic [SEL_W-1:0] {
		SEL_DRIVE_EN, SEL_FAULT, SEL_STR_ONE, SEL_STR_TWO,
		SEL_BUS_RUN, SEL_HW_EN, SEL_SW_EN, SEL_OFF
	} dei_sel_e;

endpackage : dei_pkg

// ==== logic/dei_interlock.sv ====
// dei_interlock: output stage enables, fault relay, digital output, leds,
// pushbutton action and register port of the central supply.
// assumes fault, bus and ethernet status come from logic on sys_clk;
// pins (enable, permits, pushbutton) are asynchronous.
//
// Behaviour
// - stages enabled only when hardware AND software enable
// - per string, enable needs active torque permit
// - disabled drives keep output stages off
// - one permit input, one state output per string
// - losing permit stops only that string
// - relay mode: no fault, or no fault and enabled
// - relay ignores current limit and regen threshold
// - relay follows its condition within 10 ms
// - any fault opens relay, drops hardware ready
// - digital output shows selected function, 250 us refresh
// - run led follows bus, link leds follow links
// - service port runs only at 100 Mbit/s
// - short push shows ip address
`timescale 1ns/1ps
`default_nettype none

module dei_interlock #(
	parameter int DEBOUNCE_CYC  = dei_pkg::DEBOUNCE_CYC,
	parameter int SHORT_CYC     = dei_pkg::SHORT_CYC,
	parameter int DOUT_REFR_CYC = dei_pkg::DOUT_REFR_CYC
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	// asynchronous pins
	input  wire dei_pkg::dei_pins_s pins,
	// internal status on sys_clk
	input  wire logic [7:0]        fault_src,
	input  wire logic              bus_running,
	input  wire logic              in_link_act,
	input  wire logic              out_link_act,
	input  wire logic              eth_link_up,
	input  wire logic              eth_speed_100,
	// register port
	input  wire logic [7:0]        addr,
	input  wire logic [31:0]       wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic [31:0]            rd_data,
	// drive and relay outputs
	output logic [1:0]             stage_en,
	output logic                   hw_ready,
	output logic                   string_one_torque_state,
	output logic                   string_two_torque_state,
	output logic                   fault_relay_closed,
	output logic                   dig_out,
	// indicators
	output logic                   run_led,
	output logic                   in_link_led,
	output logic                   out_link_led,
	output logic                   eth_service_ok,
	output logic                   show_ip,
	output logic                   irq
);

	////////////////////////////////////////////////////////////////////////
	// input synchroniser: a bit is taken once stages two and three agree
	dei_pkg::dei_pins_s s1_q, s2_q, s3_q, clean_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			clean_q <= '0;
		end else begin
			s1_q    <= pins;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			clean_q <= (clean_q & (s2_q ^ s3_q)) | (s2_q & s3_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register port
	dei_pkg::dei_ctrl_s          ctrl_q;
	logic [dei_pkg::EV_W-1:0]    istat_q, imask_q, events;
	logic [31:0]                 rd_q, rd_d;
	logic                        fault_c, drive_en, btn_db_q;
	logic                        relay_cond, short_push_q;
	logic [1:0]                  perm_c;
	logic                        fault_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			ctrl_q <= dei_pkg::CTRL_RST;
		else if (wr_en && addr == dei_pkg::ADDR_CTRL)
			ctrl_q <= wr_data[4:0];
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			imask_q <= dei_pkg::EV_RST;
		else if (wr_en && addr == dei_pkg::ADDR_IMASK)
			imask_q <= wr_data[dei_pkg::EV_W-1:0];
	end

	// a read clears the sticky bits; an event in the same cycle survives
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			istat_q <= dei_pkg::EV_RST;
		else if (rd_en && addr == dei_pkg::ADDR_ISTAT)
			istat_q <= events;
		else
			istat_q <= istat_q | events;
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		case (addr)
			dei_pkg::ADDR_CTRL:  rd_d[4:0] = ctrl_q;
			dei_pkg::ADDR_STATE: rd_d[9:0] = {eth_service_ok, btn_db_q,
				fault_q, hw_ready, clean_q, stage_en};
			dei_pkg::ADDR_ISTAT: rd_d[dei_pkg::EV_W-1:0] = istat_q;
			dei_pkg::ADDR_IMASK: rd_d[dei_pkg::EV_W-1:0] = imask_q;
			default:             rd_d = 32'h0000_0000;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			rd_q <= 32'h0000_0000;
		else
			rd_q <= rd_en ? rd_d : 32'h0000_0000;
	end

	assign rd_data = rd_q;
	assign irq     = |(istat_q & imask_q);

	////////////////////////////////////////////////////////////////////////
	// interlock: enables, per-string permits, fault relay
	assign perm_c   = {clean_q.string_two_torque_permit,
		clean_q.string_one_torque_permit};
	assign fault_c  = |fault_src;
	// software alone can never enable; the pin must be driven high
	assign drive_en = clean_q.hw_enable & ctrl_q.sw_enable & ~fault_c;
	// only fault, enable and relay_mode steer the relay, nothing else is wired in
	assign relay_cond = ctrl_q.relay_mode ? (~fault_c & drive_en)
		: ~fault_c;

	logic [1:0] stage_q;
	logic       ready_q, relay_q;
	logic       stage_one_en, stage_two_en;

	assign stage_one_en = drive_en & perm_c[0];
	assign stage_two_en = drive_en & perm_c[1];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stage_q <= 2'h0;
			ready_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			stage_q <= {stage_two_en, stage_one_en};
			ready_q <= drive_en;
			fault_q <= fault_c;
		end
	end

	// one cycle here is far inside the relay's allowed switching time
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			relay_q <= 1'b0;
		else
			relay_q <= relay_cond;
	end

	assign stage_en                = stage_q;
	assign hw_ready                = ready_q;
	assign fault_relay_closed      = relay_q;
	assign string_one_torque_state = clean_q.string_one_torque_permit;
	assign string_two_torque_state = clean_q.string_two_torque_permit;

	////////////////////////////////////////////////////////////////////////
	// programmable digital output, sampled on a fixed refresh tick
	logic [dei_pkg::CNT_W-1:0] refr_q;
	logic                      tick, dout_q, dout_src;

	assign tick = (refr_q == dei_pkg::CNT_W'(DOUT_REFR_CYC - 1));

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			refr_q <= '0;
		else
			refr_q <= tick ? '0 : refr_q + 1'b1;
	end

	always_comb begin
		case (dei_pkg::dei_sel_e'(ctrl_q.dout_sel))
			dei_pkg::SEL_DRIVE_EN: dout_src = ready_q;
			dei_pkg::SEL_FAULT:    dout_src = fault_q;
			dei_pkg::SEL_STR_ONE:  dout_src = perm_c[0];
			dei_pkg::SEL_STR_TWO:  dout_src = perm_c[1];
			dei_pkg::SEL_BUS_RUN:  dout_src = bus_running;
			dei_pkg::SEL_HW_EN:    dout_src = clean_q.hw_enable;
			dei_pkg::SEL_SW_EN:    dout_src = ctrl_q.sw_enable;
			default:               dout_src = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			dout_q <= 1'b0;
		else if (tick)
			dout_q <= dout_src;
	end

	assign dig_out = dout_q;

	////////////////////////////////////////////////////////////////////////
	// indicators
	logic run_q, in_q, out_q, eth_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			run_q <= 1'b0;
			in_q  <= 1'b0;
			out_q <= 1'b0;
			eth_q <= 1'b0;
		end else begin
			run_q <= bus_running;
			in_q  <= in_link_act;
			out_q <= out_link_act;
			// 10 Mbit/s links are treated as no link at all
			eth_q <= eth_link_up & eth_speed_100;
		end
	end

	assign run_led        = run_q;
	assign in_link_led    = in_q;
	assign out_link_led   = out_q;
	assign eth_service_ok = eth_q;

	////////////////////////////////////////////////////////////////////////
	// pushbutton: debounce, then time the press; long presses do nothing
	logic [dei_pkg::CNT_W-1:0] db_cnt_q, press_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			db_cnt_q <= '0;
			btn_db_q <= 1'b0;
		end else if (clean_q.front_pushbutton == btn_db_q) begin
			db_cnt_q <= '0;
		end else if (db_cnt_q == dei_pkg::CNT_W'(DEBOUNCE_CYC - 1)) begin
			db_cnt_q <= '0;
			btn_db_q <= clean_q.front_pushbutton;
		end else begin
			db_cnt_q <= db_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			press_q      <= '0;
			short_push_q <= 1'b0;
		end else begin
			short_push_q <= 1'b0;
			if (btn_db_q) begin
				if (press_q != dei_pkg::CNT_W'(SHORT_CYC))
					press_q <= press_q + 1'b1;
			end else begin
				if (press_q != '0 && press_q < dei_pkg::CNT_W'(SHORT_CYC))
					short_push_q <= 1'b1;
				press_q <= '0;
			end
		end
	end

	assign show_ip = short_push_q;

	// interrupt events
	logic [1:0] perm_prev_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			perm_prev_q <= 2'h0;
		else
			perm_prev_q <= perm_c;
	end

	assign events = {short_push_q, perm_prev_q & ~perm_c, fault_c & ~fault_q};

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_stat_read;
		rd_en && addr == dei_pkg::ADDR_ISTAT;
	endsequence

	sequence s_fault_seen;
		fault_c ##1 1'b1;
	endsequence

	a_enable_needs_both: assert property (
		|stage_en |-> $past(clean_q.hw_enable && ctrl_q.sw_enable))
		else $error("stage enabled without both enables");

	a_permit_gates_one: assert property (
		!perm_c[0] |=> !stage_en[0])
		else $error("string one enabled without permit");

	a_disabled_stages_off: assert property (
		!hw_ready |-> stage_en == 2'h0)
		else $error("stage on while drive disabled");

	a_string_independent: assert property (
		$fell(perm_c[0]) && perm_c[1] && drive_en |=> stage_en == 2'b10)
		else $error("permit loss spilled to other string");

	a_relay_mode_two: assert property (
		ctrl_q.relay_mode && !drive_en |=> !fault_relay_closed)
		else $error("relay closed while disabled in mode two");

	a_relay_follows: assert property (
		$changed(relay_cond) |=> fault_relay_closed == $past(relay_cond))
		else $error("relay late");

	a_fault_opens: assert property (
		s_fault_seen |-> !fault_relay_closed && !hw_ready && stage_en == 2'h0)
		else $error("fault did not open relay");

	a_dout_refresh: assert property (
		!$past(tick) |-> $stable(dig_out))
		else $error("digital output changed off tick");

	a_run_led: assert property (
		bus_running |=> run_led)
		else $error("run led off while bus runs");

	a_show_ip_pulse: assert property (
		show_ip |=> !show_ip ##1 !show_ip)
		else $error("show ip longer than one cycle");

	a_stat_read_clears: assert property (
		s_stat_read ##0 events == '0 |=> istat_q == '0 && rd_data[3:0] == $past(istat_q))
		else $error("status read did not clear");

endmodule : dei_interlock

`default_nettype wire

// ==== bench/dei_ctl_model.sv ====
// dei_ctl_model: machine controller and safety wiring at the pin side.
// assumes the bench calls its tasks from one process, on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module dei_ctl_model (
	// clock
	input  wire logic             sys_clk,
	// pins toward the supply
	output var dei_pkg::dei_pins_s pins
);
	////////////////////////////////////////////////////////////////////
	initial pins = '0;

	// the enable pin always gets a firm level, never left floating
	task automatic set_pins(input logic en, input logic p1, input logic p2);
		@(posedge sys_clk);
		pins.hw_enable <= en;
		pins.string_one_torque_permit <= p1;
		pins.string_two_torque_permit <= p2;
	endtask : set_pins

	// a real contact chatters once before it stays closed
	task automatic press(input int n);
		@(posedge sys_clk);
		pins.front_pushbutton <= 1'b1;
		@(posedge sys_clk);
		pins.front_pushbutton <= 1'b0;
		@(posedge sys_clk);
		pins.front_pushbutton <= 1'b1;
		repeat (n) @(posedge sys_clk);
		pins.front_pushbutton <= 1'b0;
	endtask : press
endmodule : dei_ctl_model
`default_nettype wire

// ==== bench/drive_enable_fault_interlock_tb_top.sv ====
// drive_enable_fault_interlock_tb_top: directed tests of the interlock.
// assumes short debounce, press and refresh counts set at the instance.
`timescale 1ns/1ps
`default_nettype none

module drive_enable_fault_interlock_tb_top;
	localparam int DREF = 8;
	logic               sys_clk, nrst, wr_en, rd_en;
	logic               bus_running, in_link_act, out_link_act;
	logic               eth_link_up, eth_speed_100;
	logic [7:0]         fault_src, addr;
	logic [31:0]        wr_data, rd_data, rv;
	logic [1:0]         stage_en;
	logic               hw_ready, st_one, st_two, relay, dig_out, show_ip, irq;
	logic               run_led, in_link_led, out_link_led, eth_service_ok;
	dei_pkg::dei_pins_s pins;
	int                 failures, compares, c;

	dei_ctl_model ctl (.sys_clk(sys_clk), .pins(pins));

	dei_interlock #(.DEBOUNCE_CYC(4), .SHORT_CYC(50), .DOUT_REFR_CYC(DREF)) uut (
		.sys_clk(sys_clk), .nrst(nrst), .pins(pins), .fault_src(fault_src),
		.bus_running(bus_running), .in_link_act(in_link_act),
		.out_link_act(out_link_act), .eth_link_up(eth_link_up),
		.eth_speed_100(eth_speed_100), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .stage_en(stage_en),
		.hw_ready(hw_ready), .string_one_torque_state(st_one),
		.string_two_torque_state(st_two), .fault_relay_closed(relay),
		.dig_out(dig_out), .run_led(run_led), .in_link_led(in_link_led),
		.out_link_led(out_link_led), .eth_service_ok(eth_service_ok),
		.show_ip(show_ip), .irq(irq));

	////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		chk(what, rd_data, exp);
	endtask : rchk

	function automatic logic [31:0] cw(input logic [2:0] sel, input logic md, sw);
		return 32'({sel, md, sw});
	endfunction : cw

	function automatic logic [31:0] outs();
		return 32'({stage_en, hw_ready, st_one, st_two, relay, dig_out, run_led,
			in_link_led, out_link_led, eth_service_ok, show_ip, irq});
	endfunction : outs

	task automatic pulses(input int n);
		c = 0;
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			if (show_ip === 1'b1) c++;
		end
	endtask : pulses

	task automatic close_out();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// whole run is a few hundred cycles
	initial begin
		#100000;
		failures++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		{nrst, wr_en, rd_en, bus_running, in_link_act, out_link_act} = '0;
		{eth_link_up, eth_speed_100} = 2'b11;
		{fault_src, addr, wr_data} = '0;
		settle(11);
		chk("reset outputs", outs(), 32'h0);
		@(posedge sys_clk);
		nrst <= 1'b1;
		rchk("ctrl reset", dei_pkg::ADDR_CTRL, 32'h0);
		rchk("imask reset", dei_pkg::ADDR_IMASK, 32'h0);
		wr(8'h10, 32'hffff_ffff);
		rchk("unmapped", 8'h10, 32'h0);
		wr(dei_pkg::ADDR_IMASK, 32'hf);
		settle(3);
		chk("relay mode0 idle", relay, 1'b1);
		ctl.set_pins(1'b1, 1'b1, 1'b1);
		settle(8);
		chk("stage sw off", stage_en, 2'b00);
		wr(dei_pkg::ADDR_CTRL, cw(3'h0, 1'b1, 1'b1));
		settle(2);
		chk("stage both on", stage_en, 2'b11);
		chk("relay mode1 on", relay, 1'b1);
		rchk("state", dei_pkg::ADDR_STATE, 32'h25f);
		ctl.set_pins(1'b0, 1'b1, 1'b1);
		settle(8);
		chk("stage hw off", stage_en, 2'b00);
		chk("relay mode1 off", relay, 1'b0);
		ctl.set_pins(1'b1, 1'b0, 1'b1);
		settle(8);
		chk("string one off", {stage_en, st_one, st_two}, 4'b1001);
		chk("irq permit", irq, 1'b1);
		rchk("istat permit one", dei_pkg::ADDR_ISTAT, 32'h2);
		ctl.set_pins(1'b1, 1'b1, 1'b0);
		settle(8);
		chk("string two off", {stage_en, st_one, st_two}, 4'b0110);
		rchk("istat permit two", dei_pkg::ADDR_ISTAT, 32'h4);
		chk("irq cleared", irq, 1'b0);
		ctl.set_pins(1'b1, 1'b1, 1'b1);
		bus_running <= 1'b1;
		for (int s = 0; s < 8; s++) begin
			wr(dei_pkg::ADDR_CTRL, cw(s[2:0], 1'b1, 1'b1));
			settle(DREF + 3);
			chk("dig_out", dig_out, 1'(8'h7d >> s));
		end
		@(posedge sys_clk);
		in_link_act <= 1'b1;
		eth_speed_100 <= 1'b0;
		settle(3);
		chk("leds", {run_led, in_link_led, out_link_led, eth_service_ok}, 4'b1100);
		@(posedge sys_clk);
		fault_src <= 8'h10;
		settle(2);
		chk("fault trip", {relay, hw_ready, stage_en}, 4'b0000);
		rchk("istat fault", dei_pkg::ADDR_ISTAT, 32'h1);
		@(posedge sys_clk);
		fault_src <= 8'h00;
		settle(3);
		chk("fault gone", {relay, stage_en}, 3'b111);
		wr(dei_pkg::ADDR_IMASK, 32'h0);
		fault_src <= 8'h01;
		settle(3);
		chk("irq masked", irq, 1'b0);
		wr(dei_pkg::ADDR_IMASK, 32'hf);
		settle(1);
		chk("irq unmasked", irq, 1'b1);
		@(posedge sys_clk);
		fault_src <= 8'h00;
		rchk("istat sticky", dei_pkg::ADDR_ISTAT, 32'h1);
		ctl.press(10);
		pulses(30);
		chk("short push", c, 1);
		rchk("istat push", dei_pkg::ADDR_ISTAT, 32'h8);
		ctl.press(80);
		pulses(30);
		chk("long push", c, 0);
		@(posedge sys_clk);
		nrst <= 1'b0;
		settle(2);
		chk("mid reset", outs(), 32'h0);
		@(posedge sys_clk);
		nrst <= 1'b1;
		rchk("ctrl after reset", dei_pkg::ADDR_CTRL, 32'h0);
		close_out();
	end
endmodule : drive_enable_fault_interlock_tb_top
`default_nettype wire
